// File: dv/bbl_file_space.sv
// data file register space beside the decoder
// assumes reads follow raddr at once and writes land on the strobe
`timescale 1ns/10ps
`default_nettype none
module bbl_file_space (
    input wire logic clk,
    input wire logic [6:0] raddr,
    output logic [7:0] rdata,
    input wire logic we,
    input wire logic [6:0] waddr,
    input wire logic [7:0] wdata
);
    logic [7:0] mem [128];
    // zero latches, so a port read of the pins cannot pass by luck
    initial for (int i = 0; i < 128; i++) mem[i] = 8'h00;
    assign rdata = mem[raddr];
    always @(posedge clk) if (we) mem[waddr] <= wdata;
endmodule
`default_nettype wire

// File: dv/bbl_insn_decoder_tb.sv
// self-checking bench for the instruction decoder
// assumes the file space model and the software register port
`timescale 1ns/10ps
`default_nettype none
module bbl_insn_decoder_tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [13:0] insn_word = 14'h0000;
    logic insn_valid = 1'b0;
    logic prescaler_to_timer = 1'b0;
    logic wake = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] pin_levels = 8'hC3;
    logic [7:0] reg_rdata_r, file_rdata, file_wdata_r;
    logic [6:0] file_raddr, file_waddr_r;
    logic [10:0] pc_target_r;
    logic insn_discard, file_we_r, prescaler_clr_r, pc_load_r, standby;
    logic stack_push_r, stack_pop_r, int_enable_set_r, wdt_clear_r;
    int n_fail = 0;
    int n_compared = 0;
    always #25 clk = ~clk;
    bbl_insn_decoder i_bbl_insn_decoder (.clk, .sys_rst, .insn_word,
        .insn_valid, .insn_discard, .file_raddr, .file_rdata, .pin_levels,
        .prescaler_to_timer, .wake, .file_we_r, .file_waddr_r, .file_wdata_r,
        .prescaler_clr_r, .pc_load_r, .pc_target_r, .stack_push_r,
        .stack_pop_r, .int_enable_set_r, .wdt_clear_r, .standby, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r);
    bbl_file_space i_bbl_file_space (.clk, .raddr(file_raddr),
        .rdata(file_rdata), .we(file_we_r), .waddr(file_waddr_r),
        .wdata(file_wdata_r));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [23:0] seen, input logic [23:0] want);
        n_compared++;
        if (seen !== want) begin
            n_fail++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic close_out();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // word is taken at the second edge; outputs settle 1 ns later
    task automatic run(input logic [13:0] w);
        @(posedge clk);
        insn_word <= w;
        insn_valid <= 1'b1;
        @(posedge clk);
        insn_valid <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] want);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check({16'h0000, reg_rdata_r}, {16'h0000, want});
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // file write plus skip flag of the word just taken
    task automatic fw(input logic [13:0] w, input logic [6:0] a,
                      input logic [7:0] d, input logic sk);
        run(w);
        check({7'h00, insn_discard, file_we_r, file_waddr_r, file_wdata_r},
              {7'h00, sk, 1'b1, a, d});
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd(2'h0, 8'h01);
        rd(2'h1, 8'h00);
        rd(2'h3, 8'h00);
        wr(2'h2, 8'hFF);
        rd(2'h2, 8'h00);
        wr(2'h0, 8'h00);
        run(14'h3077);
        rd(2'h2, 8'h00);
        wr(2'h0, 8'h01);
    endtask
    task automatic t_literal();
        logic [13:0] w [7] = '{14'h305A, 14'h3EA6, 14'h3830, 14'h390F,
                               14'h3A81, 14'h3C01, 14'h3000};
        logic [7:0] a [7] = '{8'h5A, 8'h00, 8'h30, 8'h00, 8'h81, 8'h80, 8'h00};
        logic [7:0] s [7] = '{8'h00, 8'h07, 8'h03, 8'h07, 8'h03, 8'h02, 8'h02};
        for (int i = 0; i < 7; i++) begin
            run(w[i]);
            rd(2'h2, a[i]);
            rd(2'h1, s[i]);
        end
    endtask
    task automatic t_byte();
        run(14'h303C);
        fw(14'h00A0, 7'h20, 8'h3C, 1'b0);
        rd(2'h1, 8'h02);
        fw(14'h08A2, 7'h22, 8'h00, 1'b0);
        rd(2'h1, 8'h06);
        fw(14'h07A0, 7'h20, 8'h78, 1'b0);
        fw(14'h17A0, 7'h20, 8'hF8, 1'b0);
        fw(14'h0885, 7'h05, 8'hC3, 1'b0);
        @(posedge clk) prescaler_to_timer <= 1'b1;
        fw(14'h0081, 7'h01, 8'h3C, 1'b0);
        check({23'h0, prescaler_clr_r}, 24'h1);
        @(posedge clk) prescaler_to_timer <= 1'b0;
        run(14'h0081);
        check({23'h0, prescaler_clr_r}, 24'h0);
        fw(14'h0DA0, 7'h20, 8'hF0, 1'b0);
        rd(2'h1, 8'h03);
        run(14'h0C20);
        rd(2'h2, 8'hF8);
        rd(2'h1, 8'h02);
    endtask
    task automatic t_skip();
        logic [13:0] w [4] = '{14'h1820, 14'h1BA0, 14'h1FA0, 14'h1C20};
        logic k [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 4; i++) begin
            run(w[i]);
            check({23'h0, insn_discard}, {23'h0, k[i]});
        end
        run(14'h3001);
        run(14'h00A1);
        fw(14'h0BA1, 7'h21, 8'h00, 1'b1);
        fw(14'h0FA1, 7'h21, 8'h01, 1'b0);
        check({17'h0, file_raddr}, 24'h21);
    endtask
    task automatic t_ctrl();
        @(posedge clk);
        insn_word <= 14'h2923;
        insn_valid <= 1'b1;
        // word offered in the discard cycle must be dropped
        @(posedge clk);
        insn_word <= 14'h3099;
        #1;
        check({11'h0, pc_load_r, insn_discard, pc_target_r}, 24'h1923);
        @(posedge clk);
        insn_valid <= 1'b0;
        rd(2'h2, 8'h01);
        run(14'h2005);
        check({21'h0, stack_push_r, pc_load_r, insn_discard}, 24'h7);
        run(14'h0009);
        check({23'h0, int_enable_set_r}, 24'h1);
        check({22'h0, stack_pop_r, insn_discard}, 24'h3);
        run(14'h0064);
        check({22'h0, wdt_clear_r, insn_discard}, 24'h2);
        run(14'h3442);
        check({22'h0, stack_pop_r, insn_discard}, 24'h3);
        rd(2'h2, 8'h42);
        run(14'h0063);
        check({23'h0, standby}, 24'h1);
        run(14'h3055);
        rd(2'h2, 8'h42);
        rd(2'h1, 8'h0A);
        @(posedge clk) wake <= 1'b1;
        @(posedge clk) wake <= 1'b0;
        #1;
        check({23'h0, standby}, 24'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_literal();
        t_byte();
        t_skip();
        t_ctrl();
        close_out();
    end
    // hang guard: a stalled run counts as a mismatch
    initial begin
        #200000;
        n_fail++;
        close_out();
    end
endmodule
`default_nettype wire

// File: src/bbl_insn_decoder.sv
// decoder and executor for 14-bit byte, bit, literal and control words
// assumes an external program sequencer and file register space; file
// reads are combinational on file_raddr, writes land one cycle later
//
// Notes on behaviour
// [RL1] byte ops: d=0 writes accumulator, d=1 writes the file register
// [RL2] file address is 7 bits (0..127), bit select is 3 bits (0..7)
// [RL3] bit set forces the chosen bit to one, flags untouched
// [RL4] skip-if-clear: bit zero discards next word, two cycles
// [RL5] skip-if-set: bit one discards next word, opcode bits 11
// [RL6] jumps, returns and true skips take two cycles, second a no-op
// [RL7] reading the port address uses pin levels, not the latch
// [RL8] writing the timer count clears the prescaler when assigned there
// [RL9] add literal: acc plus k into acc, updates C, half carry, Z
// [RL10] and literal: acc and k into acc, only Z changes
// [RL11] move file copies to destination and sets Z from the value
// [RL12] move literal loads acc, flags untouched
// [RL13] store acc to file in one cycle, flags untouched
// [RL14] decrement/increment skip on zero, flags untouched, 1011/1111
// [RL15] rotates go through carry, only C changes, 1101/1100
// [RL16] subtract from literal: k minus acc into acc, C, half carry, Z
// [RL17] xor literal: acc xor k into acc, only Z changes
// [RL18] or literal: acc or k into acc, only Z changes
// [RL19] return with literal loads acc, returns, two cycles
// [RL20] standby word 00 0000 0110 0011 enters standby next cycle
// [RL21] Z on zero result, C out of bit 7, half carry out of bit 3
// [RL22] classes by top bits: 00 byte, 01 bit, 10 jump, 11 literal
`timescale 1ns/10ps
`default_nettype none
`include "bbl_params.svh"

module bbl_insn_decoder #(
    parameter int unsigned IW = 14,
    parameter int unsigned DW = 8,
    parameter int unsigned AW = 7
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [IW-1:0] insn_word,
    input wire logic insn_valid,
    output logic insn_discard,
    output logic [AW-1:0] file_raddr,
    input wire logic [DW-1:0] file_rdata,
    input wire logic [DW-1:0] pin_levels,
    input wire logic prescaler_to_timer,
    input wire logic wake,
    output logic file_we_r,
    output logic [AW-1:0] file_waddr_r,
    output logic [DW-1:0] file_wdata_r,
    output logic prescaler_clr_r,
    output logic pc_load_r,
    output logic [10:0] pc_target_r,
    output logic stack_push_r,
    output logic stack_pop_r,
    output logic int_enable_set_r,
    output logic wdt_clear_r,
    output logic standby,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata_r
);

    ////////////////////////////////////////////////////////////////////
    // fields of the word

    logic [1:0] cls;
    logic [3:0] bop;
    logic [1:0] bitop;
    logic dsel;
    logic [AW-1:0] faddr;
    logic [2:0] bsel;
    logic [DW-1:0] lit;

    assign cls = insn_word[13:12]; // RL22
    assign bop = insn_word[11:8];
    assign bitop = insn_word[11:10];
    assign dsel = insn_word[7];
    assign faddr = insn_word[6:0]; // RL2
    assign bsel = insn_word[9:7]; // RL2
    assign lit = insn_word[7:0];
    assign file_raddr = faddr;

    ////////////////////////////////////////////////////////////////////
    // state

    bbl_pkg::bbl_state_e state_r;
    logic [DW-1:0] acc_r;
    logic c_r;
    logic hc_r;
    logic z_r;
    logic run_r;
    logic exec;

    assign exec = insn_valid && run_r && (state_r == bbl_pkg::st_exec);
    assign insn_discard = (state_r == bbl_pkg::st_flush); // RL6
    assign standby = (state_r == bbl_pkg::st_standby);

    ////////////////////////////////////////////////////////////////////
    // operand source

    logic [DW-1:0] src;

    // forward the pending write, the file space lands it one cycle late
    always_comb begin
        if (faddr == `BBL_ADDR_PORT) begin
            src = pin_levels; // RL7
        end else if (file_we_r && file_waddr_r == faddr) begin
            src = file_wdata_r;
        end else begin
            src = file_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // adder shared by byte and literal add/subtract

    logic [DW-1:0] opnd;
    logic [8:0] add_s;
    logic [4:0] add_h;
    logic [8:0] sub_s;
    logic [4:0] sub_h;

    assign opnd = (cls == `BBL_CLS_LIT) ? lit : src;
    assign add_s = {1'b0, acc_r} + {1'b0, opnd}; // RL21
    assign add_h = {1'b0, acc_r[3:0]} + {1'b0, opnd[3:0]}; // RL21
    // carry out means no borrow
    assign sub_s = {1'b0, opnd} + {1'b0, ~acc_r} + 9'h001; // RL21
    assign sub_h = {1'b0, opnd[3:0]} + {1'b0, ~acc_r[3:0]} + 5'h01;

    ////////////////////////////////////////////////////////////////////
    // decode

    bbl_pkg::bbl_ctl_s ctl;
    logic [DW-1:0] res;
    logic c_n;
    logic hc_n;
    logic [DW-1:0] mask;
    logic dest;

    assign mask = 8'h01 << bsel;

    always_comb begin
        ctl = '0;
        res = acc_r;
        c_n = c_r;
        hc_n = hc_r;
        dest = 1'b0;
        case (cls)
            `BBL_CLS_BYTE: begin
                dest = 1'b1;
                case (bop)
                    `BBL_OP_STORE: begin
                        dest = 1'b0;
                        if (dsel) begin
                            ctl.wr_file = 1'b1; // RL13
                        end else begin
                            case (lit)
                                `BBL_CW_RETURN: begin
                                    ctl.pop = 1'b1;
                                end
                                `BBL_CW_RETINT: begin
                                    ctl.pop = 1'b1;
                                    ctl.int_en = 1'b1;
                                end
                                `BBL_CW_STANDBY: begin
                                    ctl.sleep = 1'b1; // RL20
                                end
                                `BBL_CW_WDTCLR: begin
                                    ctl.wdt_clr = 1'b1;
                                end
                                default: begin
                                end
                            endcase
                        end
                    end
                    `BBL_OP_CLEAR: begin
                        res = 8'h00;
                        ctl.upd_z = 1'b1;
                    end
                    `BBL_OP_SUBWF: begin
                        res = sub_s[7:0];
                        c_n = sub_s[8];
                        hc_n = sub_h[4];
                        ctl.upd_z = 1'b1;
                        ctl.upd_c = 1'b1;
                    end
                    `BBL_OP_DECF: begin
                        res = src - 8'h01;
                        ctl.upd_z = 1'b1;
                    end
                    `BBL_OP_IORWF: begin
                        res = acc_r | src;
                        ctl.upd_z = 1'b1;
                    end
                    `BBL_OP_ANDWF: begin
                        res = acc_r & src;
                        ctl.upd_z = 1'b1;
                    end
                    `BBL_OP_XORWF: begin
                        res = acc_r ^ src;
                        ctl.upd_z = 1'b1;
                    end
                    `BBL_OP_ADDACC: begin
                        res = add_s[7:0];
                        c_n = add_s[8];
                        hc_n = add_h[4];
                        ctl.upd_z = 1'b1;
                        ctl.upd_c = 1'b1;
                    end
                    `BBL_OP_MOVE: begin
                        res = src;
                        ctl.upd_z = 1'b1; // RL11
                    end
                    `BBL_OP_COMF: begin
                        res = ~src;
                        ctl.upd_z = 1'b1;
                    end
                    `BBL_OP_INCF: begin
                        res = src + 8'h01;
                        ctl.upd_z = 1'b1;
                    end
                    `BBL_OP_DECSKIP: begin
                        res = src - 8'h01;
                        ctl.skip = (res == 8'h00); // RL14
                    end
                    `BBL_OP_INCSKIP: begin
                        res = src + 8'h01;
                        ctl.skip = (res == 8'h00); // RL14
                    end
                    `BBL_OP_ROTR: begin
                        res = {c_r, src[7:1]};
                        c_n = src[0]; // RL15
                        hc_n = hc_r;
                        ctl.upd_c = 1'b1;
                    end
                    `BBL_OP_ROTL: begin
                        res = {src[6:0], c_r};
                        c_n = src[7]; // RL15
                        hc_n = hc_r;
                        ctl.upd_c = 1'b1;
                    end
                    `BBL_OP_SWAPF: begin
                        res = {src[3:0], src[7:4]};
                    end
                    default: begin
                    end
                endcase
                if (dest) begin
                    ctl.wr_file = dsel; // RL1
                    ctl.wr_acc = !dsel; // RL1
                end
            end
            `BBL_CLS_BIT: begin
                res = src;
                case (bitop)
                    `BBL_BOP_CLR: begin
                        res = src & ~mask;
                        ctl.wr_file = 1'b1;
                    end
                    `BBL_BOP_SET: begin
                        res = src | mask; // RL3
                        ctl.wr_file = 1'b1;
                    end
                    `BBL_BOP_SKIPCLR: begin
                        ctl.skip = !src[bsel]; // RL4
                    end
                    `BBL_BOP_SKIPSET: begin
                        ctl.skip = src[bsel]; // RL5
                    end
                    default: begin
                    end
                endcase
            end
            `BBL_CLS_JUMP: begin
                ctl.jump = 1'b1; // RL6
                ctl.push = !insn_word[11];
            end
            `BBL_CLS_LIT: begin
                ctl.wr_acc = 1'b1;
                ctl.upd_z = 1'b1;
                casez (bop)
                    `BBL_LOP_MOVE: begin
                        res = lit;
                        ctl.upd_z = 1'b0; // RL12
                    end
                    `BBL_LOP_RET: begin
                        res = lit;
                        ctl.upd_z = 1'b0;
                        ctl.pop = 1'b1; // RL19
                    end
                    `BBL_LOP_OR: begin
                        res = acc_r | lit; // RL18
                    end
                    `BBL_LOP_AND: begin
                        res = acc_r & lit; // RL10
                    end
                    `BBL_LOP_XOR: begin
                        res = acc_r ^ lit; // RL17
                    end
                    `BBL_LOP_SUB: begin
                        res = sub_s[7:0]; // RL16
                        c_n = sub_s[8];
                        hc_n = sub_h[4];
                        ctl.upd_c = 1'b1;
                    end
                    `BBL_LOP_ADD: begin
                        res = add_s[7:0]; // RL9
                        c_n = add_s[8];
                        hc_n = add_h[4];
                        ctl.upd_c = 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
            default: begin
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // sequencing

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= bbl_pkg::st_exec;
        end else begin
            case (state_r)
                bbl_pkg::st_exec: begin
                    if (exec && ctl.sleep) begin
                        state_r <= bbl_pkg::st_standby; // RL20
                    end else if (exec &&
                                 (ctl.skip || ctl.jump || ctl.pop)) begin
                        state_r <= bbl_pkg::st_flush; // RL6
                    end
                end
                bbl_pkg::st_flush: begin
                    state_r <= bbl_pkg::st_exec;
                end
                bbl_pkg::st_standby: begin
                    if (wake) begin
                        state_r <= bbl_pkg::st_exec;
                    end
                end
                default: begin
                    state_r <= bbl_pkg::st_exec;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // accumulator and flags

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_r <= `BBL_ACC_RST;
        end else if (exec && ctl.wr_acc) begin
            acc_r <= res; // RL1
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            c_r <= 1'b0;
            hc_r <= 1'b0;
            z_r <= 1'b0;
        end else if (exec) begin
            if (ctl.upd_z) begin
                z_r <= (res == 8'h00); // RL21
            end
            if (ctl.upd_c) begin
                c_r <= c_n; // RL21
                hc_r <= hc_n;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // file write and side effects

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            file_we_r <= 1'b0;
            file_waddr_r <= '0;
            file_wdata_r <= '0;
            prescaler_clr_r <= 1'b0;
        end else begin
            file_we_r <= exec && ctl.wr_file; // RL1
            if (exec && ctl.wr_file) begin
                file_waddr_r <= faddr;
                file_wdata_r <= res;
            end
            prescaler_clr_r <= exec && ctl.wr_file &&
                (faddr == `BBL_ADDR_TIMER) && prescaler_to_timer; // RL8
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pc_load_r <= 1'b0;
            pc_target_r <= '0;
            stack_push_r <= 1'b0;
            stack_pop_r <= 1'b0;
            int_enable_set_r <= 1'b0;
            wdt_clear_r <= 1'b0;
        end else begin
            pc_load_r <= exec && ctl.jump; // RL6
            if (exec && ctl.jump) begin
                pc_target_r <= insn_word[10:0];
            end
            stack_push_r <= exec && ctl.push;
            stack_pop_r <= exec && ctl.pop; // RL19
            int_enable_set_r <= exec && ctl.int_en;
            wdt_clear_r <= exec && ctl.wdt_clr;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // software register port

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            run_r <= `BBL_CTRL_RST;
        end else if (reg_wr && reg_addr == `BBL_REG_CTRL) begin
            run_r <= reg_wdata[0];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata_r <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `BBL_REG_CTRL: reg_rdata_r <= {7'h00, run_r};
                `BBL_REG_STATUS:
                    reg_rdata_r <= {4'h0, standby, z_r, hc_r, c_r};
                `BBL_REG_ACC: reg_rdata_r <= acc_r;
                default: reg_rdata_r <= 8'h00;
            endcase
        end else begin
            reg_rdata_r <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence flush_then_exec;
        (state_r == bbl_pkg::st_flush) ##1 (state_r == bbl_pkg::st_exec);
    endsequence

    logic is_byte_dest;
    assign is_byte_dest = exec && cls == `BBL_CLS_BYTE && dest;

    dest_select_a: assert property ( // RL1
        is_byte_dest |=> (file_we_r == $past(dsel)) &&
            (acc_r == ($past(dsel) ? $past(acc_r) : $past(res))))
        else $error("destination select wrong");

    bit_set_a: assert property ( // RL3
        exec && cls == `BBL_CLS_BIT && bitop == `BBL_BOP_SET
        |=> file_we_r && file_wdata_r == ($past(src) | $past(mask))
            && $stable({c_r, hc_r, z_r}))
        else $error("bit set wrong");

    skip_clear_a: assert property ( // RL4
        exec && cls == `BBL_CLS_BIT && bitop == `BBL_BOP_SKIPCLR &&
        !src[bsel] |=> flush_then_exec)
        else $error("skip on clear bit missing");

    skip_set_a: assert property ( // RL5
        exec && cls == `BBL_CLS_BIT && bitop == `BBL_BOP_SKIPSET &&
        !src[bsel] |=> state_r == bbl_pkg::st_exec)
        else $error("skip on set bit taken wrongly");

    jump_two_cycle_a: assert property ( // RL6
        exec && cls == `BBL_CLS_JUMP |=> pc_load_r && insn_discard
            ##1 !insn_discard)
        else $error("jump not two cycles");

    pin_source_a: assert property ( // RL7
        exec && cls == `BBL_CLS_BYTE && bop == `BBL_OP_MOVE && !dsel &&
        faddr == `BBL_ADDR_PORT |=> acc_r == $past(pin_levels))
        else $error("port read not from pins");

    prescaler_clr_a: assert property ( // RL8
        prescaler_clr_r |-> $past(exec) && $past(faddr) == `BBL_ADDR_TIMER
            && $past(prescaler_to_timer) && file_we_r)
        else $error("prescaler clear wrong");

    add_literal_a: assert property ( // RL9
        exec && cls == `BBL_CLS_LIT && bop[3:1] == 3'h7
        |=> {c_r, acc_r} == ({1'b0, $past(acc_r)} + {1'b0, $past(lit)}))
        else $error("add literal wrong");

    move_literal_a: assert property ( // RL12
        exec && cls == `BBL_CLS_LIT && bop[3:2] == 2'h0
        |=> acc_r == $past(lit) && $stable({c_r, hc_r, z_r}))
        else $error("move literal wrong");

    standby_entry_a: assert property ( // RL20
        exec && insn_word == 14'h0063 |=> standby)
        else $error("standby not entered");

endmodule

`default_nettype wire

// File: src/bbl_params.svh
// constants of the byte/bit/literal instruction decoder
// assumes inclusion by bare name from the decoder
`ifndef BBL_PARAMS_SVH
`define BBL_PARAMS_SVH

// instruction classes, top two bits of the word
`define BBL_CLS_BYTE 2'h0
`define BBL_CLS_BIT 2'h1
`define BBL_CLS_JUMP 2'h2
`define BBL_CLS_LIT 2'h3

// byte-oriented opcodes, bits 11:8
`define BBL_OP_STORE 4'h0
`define BBL_OP_CLEAR 4'h1
`define BBL_OP_SUBWF 4'h2
`define BBL_OP_DECF 4'h3
`define BBL_OP_IORWF 4'h4
`define BBL_OP_ANDWF 4'h5
`define BBL_OP_XORWF 4'h6
`define BBL_OP_ADDACC 4'h7
`define BBL_OP_MOVE 4'h8
`define BBL_OP_COMF 4'h9
`define BBL_OP_INCF 4'hA
`define BBL_OP_DECSKIP 4'hB
`define BBL_OP_ROTR 4'hC
`define BBL_OP_ROTL 4'hD
`define BBL_OP_SWAPF 4'hE
`define BBL_OP_INCSKIP 4'hF

// bit-oriented opcodes, bits 11:10
`define BBL_BOP_CLR 2'h0
`define BBL_BOP_SET 2'h1
`define BBL_BOP_SKIPCLR 2'h2
`define BBL_BOP_SKIPSET 2'h3

// control words, low byte with bits 13:8 all zero
`define BBL_CW_RETURN 8'h08
`define BBL_CW_RETINT 8'h09
`define BBL_CW_STANDBY 8'h63
`define BBL_CW_WDTCLR 8'h64

// literal opcodes, bits 11:8 (casez patterns)
`define BBL_LOP_MOVE 4'b00??
`define BBL_LOP_RET 4'b01??
`define BBL_LOP_OR 4'b1000
`define BBL_LOP_AND 4'b1001
`define BBL_LOP_XOR 4'b1010
`define BBL_LOP_SUB 4'b110?
`define BBL_LOP_ADD 4'b111?

// special file addresses
`define BBL_ADDR_TIMER 7'h01
`define BBL_ADDR_PORT 7'h05

// software register port
`define BBL_REG_CTRL 2'h0
`define BBL_REG_STATUS 2'h1
`define BBL_REG_ACC 2'h2
`define BBL_CTRL_RST 1'h1
`define BBL_ACC_RST 8'h00
`define BBL_ST_C 0
`define BBL_ST_HC 1
`define BBL_ST_Z 2
`define BBL_ST_STBY 3

`endif

// File: src/bbl_pkg.sv
// types used by the instruction decoder; its bench does not use them
// assumes bbl_params.svh is on the include path
package bbl_pkg;

    typedef enum logic [2:0] {
        st_exec = 3'b001,
        st_flush = 3'b010,
        st_standby = 3'b100
    } bbl_state_e;

    typedef struct packed {
        logic wr_acc;
        logic wr_file;
        logic upd_z;
        logic upd_c;
        logic skip;
        logic jump;
        logic push;
        logic pop;
        logic int_en;
        logic sleep;
        logic wdt_clr;
    } bbl_ctl_s;

endpackage
